// ### common/can_ident_pkg.sv
/*
 Package for the message-buffer identifier block: register offsets, field
 positions, frame field widths and carrier structs.
 Assumes a byte-wide register port with one-cycle read latency.
*/
package can_ident_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [1:0] OFF_IDENT_BYTE_0 = 2'h0;
   localparam logic [1:0] OFF_IDENT_BYTE_1 = 2'h1;
   localparam logic [1:0] OFF_IDENT_BYTE_2 = 2'h2;
   localparam logic [1:0] OFF_IDENT_BYTE_3 = 2'h3;
   localparam int NUM_IDENT_BYTES = 4;

   // ------------------------------------------------------------
   // Field positions inside ident_byte_1 and ident_byte_3
   // ------------------------------------------------------------
   localparam int POS_EXT_SUBREM = 4;
   localparam int POS_IDEXT = 3;
   localparam int POS_EXT_REMREQ = 0;
   localparam int POS_STD_REMREQ = 4;

   // ------------------------------------------------------------
   // Frame field widths
   // ------------------------------------------------------------
   localparam int EXT_ID_BITS = 29;
   localparam int STD_ID_BITS = 11;
   localparam int EXT_HEADER_BITS = 32;
   localparam int STD_HEADER_BITS = 13;

   // Value shipped out on reset before software loads anything
   localparam logic [7:0] IDENT_RESET_VALUE = 8'h00;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic write;
      logic read;
   } reg_req_t;

   // Decoded frame header: what a protocol engine sends or receives
   typedef struct packed {
      logic [28:0] ident;
      logic subRemote;
      logic idExtended;
      logic remoteReq;
   } frame_hdr_t;

endpackage

// ### rtl/can_ident_fields.sv
/*
 Identifier bytes of one message buffer: four byte registers, decode to a
 frame header for transmit, load from a received header, serial send of
 the arbitration field and a priority compare against a competitor.
 Assumes a byte-wide register port with read data one cycle after strobe.
*/
// Decided for this implementation: the strobed register port.
// Summary of operation
// - Extended layout stores 29 identifier bits plus substitute, extension, remote bits.
// - Standard layout stores 11 identifier bits plus remote and extension bits.
// - Extended identifier bit 28 goes out first in arbitration.
// - Standard identifier bit 10 goes out first in arbitration.
// - Smaller identifier value has higher priority.
// - Received substitute-remote bit is stored as seen on the bus.
// - Extension bit selects standard or extended format for transmit.
// - Extension bit is loaded from the received frame.
// - Remote bit selects data or remote frame for transmit.
// - Remote bit of a received frame is captured.
// - Extended bytes 0 and 2 hold identifier bits 28:21 and 14:7.
// - Extended byte 1 holds ID20:18, substitute, extension, ID17:15.
// - Extended byte 3 holds ID6:0 and the remote bit at bit 0.
// - Standard bytes 0,1 hold ID10:3, then ID2:0, remote, extension.
// - Unused identifier bits read back whatever is stored, not defined.
// - Identifier bytes have no defined contents after reset.
`timescale 1ns/1ps
module can_ident_fields (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Register port
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   // Receive side from the protocol engine
   input wire logic rxStore,
   input can_ident_pkg::frame_hdr_t rxHeader,
   // Transmit side towards the protocol engine
   output can_ident_pkg::frame_hdr_t txHeader,
   input wire logic txStart,
   output logic txBitValid,
   output logic txBit,
   output logic txDone,
   // Priority compare against another buffer
   input can_ident_pkg::frame_hdr_t otherHeader,
   output logic winsPriority
);
   import can_ident_pkg::*;

   logic [7:0] identBytes [NUM_IDENT_BYTES];
   logic [7:0] next_identBytes [NUM_IDENT_BYTES];
   frame_hdr_t bufHeader;
   logic [7:0] readData;

   // ------------------------------------------------------------
   // Layout helpers
   // ------------------------------------------------------------

   // Aligned 29-bit sort key: standard identifiers sit in the top 11 bits
   function automatic logic [28:0] sortKey(input frame_hdr_t h);
      if (h.idExtended)
         sortKey = h.ident;
      else
         sortKey = {h.ident[10:0], 18'h0};
   endfunction

   // Pack a header into the four identifier bytes
   function automatic logic [31:0] packHeader(input frame_hdr_t h);
      if (h.idExtended) begin
         packHeader = {h.ident[28:21],
                       h.ident[20:18], h.subRemote, h.idExtended, h.ident[17:15],
                       h.ident[14:7],
                       h.ident[6:0], h.remoteReq};
      end else begin
         packHeader = {h.ident[10:3],
                       h.ident[2:0], h.remoteReq, h.idExtended, 3'h0,
                       16'h0};
      end
   endfunction

   // ------------------------------------------------------------
   // Byte storage
   // ------------------------------------------------------------

   // Next-value logic: software write or received frame
   always_comb begin
      logic [31:0] packed_rx;
      packed_rx = packHeader(rxHeader);
      for (int i = 0; i < NUM_IDENT_BYTES; i++)
         next_identBytes[i] = identBytes[i];
      if (rxStore) begin
         next_identBytes[0] = packed_rx[31:24];
         next_identBytes[1] = packed_rx[23:16];
         next_identBytes[2] = packed_rx[15:8];
         next_identBytes[3] = packed_rx[7:0];
      end else if (regWrite) begin
         // a write stores the byte, nothing more
         next_identBytes[regAddr] = regWdata;
      end
   end

   // Storage has no reset: contents undefined until written
   always_ff @(posedge clock) begin
      for (int i = 0; i < NUM_IDENT_BYTES; i++)
         identBytes[i] <= next_identBytes[i];
   end

   // ------------------------------------------------------------
   // Decode stored bytes into a header
   // ------------------------------------------------------------

   // Extension bit selects layout
   always_comb begin
      bufHeader.idExtended = identBytes[1][POS_IDEXT];
      if (bufHeader.idExtended) begin
         bufHeader.ident = {identBytes[0], identBytes[1][7:5], identBytes[1][2:0],
                            identBytes[2], identBytes[3][7:1]};
         bufHeader.subRemote = identBytes[1][POS_EXT_SUBREM]; // set by software or by a received frame
         bufHeader.remoteReq = identBytes[3][POS_EXT_REMREQ];
      end else begin
         bufHeader.ident = {18'h0, identBytes[0], identBytes[1][7:5]};
         bufHeader.subRemote = 1'b0;
         bufHeader.remoteReq = identBytes[1][POS_STD_REMREQ];
      end
   end

   // Header register towards the engine
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         txHeader <= '0;
      else
         txHeader <= bufHeader;
   end

   // ------------------------------------------------------------
   // Register read
   // ------------------------------------------------------------

   // Read returns stored byte; no side effect
   always_comb begin
      readData = identBytes[regAddr];
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         regRdata <= IDENT_RESET_VALUE;
      else if (regRead)
         regRdata <= readData;
   end

   // ------------------------------------------------------------
   // Arbitration serial output
   // ------------------------------------------------------------

   // MSB first for both layouts
   can_ident_shifter shifter (
      .clock(clock),
      .resetn(resetn),
      .load(txStart),
      .header(txHeader),
      .bitValid(txBitValid),
      .bitOut(txBit),
      .done(txDone)
   );

   // ------------------------------------------------------------
   // Priority compare
   // ------------------------------------------------------------

   // Smaller key wins; tie broken towards this buffer
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         winsPriority <= 1'b0;
      else
         winsPriority <= (sortKey(txHeader) <= sortKey(otherHeader));
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------

   sequence write_s;
      regWrite && !rxStore;
   endsequence

   sequence read_s;
      regRead;
   endsequence

   // Serialiser loaded with a standard or an extended header
   sequence std_start_s;
      txStart && !txHeader.idExtended;
   endsequence

   sequence ext_start_s;
      txStart && txHeader.idExtended;
   endsequence

   // Load, then so many cycles with no reload
   sequence std_run11_s;
      std_start_s ##1 !txStart [*8] ##1 !txStart [*3];
   endsequence

   sequence std_run12_s;
      std_start_s ##1 !txStart [*8] ##1 !txStart [*4];
   endsequence

   sequence ext_run11_s;
      ext_start_s ##1 !txStart [*8] ##1 !txStart [*3];
   endsequence

   sequence ext_run12_s;
      ext_start_s ##1 !txStart [*8] ##1 !txStart [*4];
   endsequence

   sequence ext_run31_s;
      ext_start_s ##1 !txStart [*8] ##1 !txStart [*8] ##1 !txStart [*8] ##1 !txStart [*7];
   endsequence

   write_store_a: assert property (@(posedge clock) disable iff (!resetn)
      write_s |=> identBytes[$past(regAddr)] == $past(regWdata))
      else $error("written byte not stored");

   read_return_a: assert property (@(posedge clock) disable iff (!resetn)
      read_s ##0 (!regWrite && !rxStore) |=> regRdata == identBytes[$past(regAddr)])
      else $error("read data mismatch");

   rx_ext_a: assert property (@(posedge clock) disable iff (!resetn)
      rxStore && rxHeader.idExtended |=> identBytes[0] == $past(rxHeader.ident[28:21])
         && identBytes[2] == $past(rxHeader.ident[14:7]))
      else $error("extended byte 0 or 2 wrong");

   rx_byte1_a: assert property (@(posedge clock) disable iff (!resetn)
      rxStore && rxHeader.idExtended |=> identBytes[1][4] == $past(rxHeader.subRemote)
         && identBytes[1][3] && identBytes[1][2:0] == $past(rxHeader.ident[17:15]))
      else $error("extended byte 1 wrong");

   rx_rtr_a: assert property (@(posedge clock) disable iff (!resetn)
      rxStore && rxHeader.idExtended |=> identBytes[3] == {$past(rxHeader.ident[6:0]),
         $past(rxHeader.remoteReq)})
      else $error("extended byte 3 wrong");

   rx_std_a: assert property (@(posedge clock) disable iff (!resetn)
      rxStore && !rxHeader.idExtended |=> identBytes[0] == $past(rxHeader.ident[10:3])
         && identBytes[1][4] == $past(rxHeader.remoteReq) && !identBytes[1][3])
      else $error("standard bytes wrong");

   ext_first_a: assert property (@(posedge clock) disable iff (!resetn)
      txStart && txHeader.idExtended |=> txBitValid && txBit == $past(txHeader.ident[28]))
      else $error("extended MSB not first");

   std_first_a: assert property (@(posedge clock) disable iff (!resetn)
      txStart && !txHeader.idExtended |=> txBitValid && txBit == $past(txHeader.ident[10]))
      else $error("standard MSB not first");

   frame_len_a: assert property (@(posedge clock) disable iff (!resetn)
      std_run12_s |=> txDone)
      else $error("standard header length wrong");

   // ------------------------------------------------------------
   // Checks: serial framing, bit by bit
   // ------------------------------------------------------------

   // A reload in mid-shift restarts the count, so each run demands quiet cycles
   std_ide_a: assert property (@(posedge clock) disable iff (!resetn)
      std_run12_s |=> !txBit)
      else $error("standard extension bit not last");

   std_rtr_a: assert property (@(posedge clock) disable iff (!resetn)
      std_run11_s |=> txBit == $past(txHeader.remoteReq, 12))
      else $error("standard remote bit misplaced");

   ext_srr_a: assert property (@(posedge clock) disable iff (!resetn)
      ext_run11_s |=> txBit == $past(txHeader.subRemote, 12))
      else $error("extended substitute bit misplaced");

   ext_ide_a: assert property (@(posedge clock) disable iff (!resetn)
      ext_run12_s |=> txBit)
      else $error("extended extension bit misplaced");

   ext_len_a: assert property (@(posedge clock) disable iff (!resetn)
      ext_run31_s |=> txDone)
      else $error("extended header length wrong");

   ext_rtr_a: assert property (@(posedge clock) disable iff (!resetn)
      ext_run31_s |=> txBit == $past(txHeader.remoteReq, 32))
      else $error("extended remote bit misplaced");

   // Nothing shifts once the last bit has gone
   done_idle_a: assert property (@(posedge clock) disable iff (!resetn)
      txDone && !txStart |=> !txBitValid)
      else $error("serialiser runs past last bit");

   // ------------------------------------------------------------
   // Checks: decode towards the engine
   // ------------------------------------------------------------

   // Header register follows the stored bytes one cycle later
   dec_ext_a: assert property (@(posedge clock) disable iff (!resetn)
      identBytes[1][POS_IDEXT] |=> txHeader.idExtended
         && txHeader.subRemote == $past(identBytes[1][POS_EXT_SUBREM])
         && txHeader.remoteReq == $past(identBytes[3][POS_EXT_REMREQ])
         && txHeader.ident == $past({identBytes[0], identBytes[1][7:5], identBytes[1][2:0],
         identBytes[2], identBytes[3][7:1]}))
      else $error("extended decode wrong");

   dec_std_a: assert property (@(posedge clock) disable iff (!resetn)
      !identBytes[1][POS_IDEXT] |=> !txHeader.idExtended
         && txHeader.remoteReq == $past(identBytes[1][POS_STD_REMREQ])
         && txHeader.ident[10:0] == $past({identBytes[0], identBytes[1][7:5]}))
      else $error("standard decode wrong");

   // ------------------------------------------------------------
   // Checks: priority and register port
   // ------------------------------------------------------------

   // Like formats compared on the identifier value alone
   prio_win_a: assert property (@(posedge clock) disable iff (!resetn)
      txHeader.idExtended && otherHeader.idExtended && txHeader.ident < otherHeader.ident
         |=> winsPriority)
      else $error("smaller identifier lost");

   prio_lose_a: assert property (@(posedge clock) disable iff (!resetn)
      txHeader.idExtended && otherHeader.idExtended && txHeader.ident > otherHeader.ident
         |=> !winsPriority)
      else $error("larger identifier won");

   prio_std_a: assert property (@(posedge clock) disable iff (!resetn)
      !txHeader.idExtended && !otherHeader.idExtended && txHeader.ident[10:0] > otherHeader.ident[10:0]
         |=> !winsPriority)
      else $error("larger standard identifier won");

   // Read data only move on a read strobe
   rdata_hold_a: assert property (@(posedge clock) disable iff (!resetn)
      !regRead |=> $stable(regRdata))
      else $error("read data changed without a read");

   read_quiet_a: assert property (@(posedge clock) disable iff (!resetn)
      read_s ##0 (!regWrite && !rxStore) |=> identBytes[0] == $past(identBytes[0])
         && identBytes[1] == $past(identBytes[1]) && identBytes[2] == $past(identBytes[2])
         && identBytes[3] == $past(identBytes[3]))
      else $error("read disturbed stored bytes");

endmodule

// ### rtl/can_ident_shifter.sv
/*
 Serialises the identifier header most significant bit first for
 arbitration: extended or standard sequence per the extension bit.
 Copies the header at load, so the caller may change it before done.
*/
`timescale 1ns/1ps
module can_ident_shifter (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Header to send
   input wire logic load,
   input can_ident_pkg::frame_hdr_t header,
   // Serial bit out
   output logic bitValid,
   output logic bitOut,
   output logic done
);
   import can_ident_pkg::*;

   logic [31:0] shiftReg;
   logic [5:0] bitsLeft;

   // ------------------------------------------------------------
   // Shift register, MSB of identifier leaves first
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         shiftReg <= 32'h0;
         bitsLeft <= 6'h00;
      end else if (load) begin
         if (header.idExtended) begin
            // ID28..ID18, SRR, IDE, ID17..ID0, RTR
            shiftReg <= {header.ident[28:18], header.subRemote, header.idExtended,
                         header.ident[17:0], header.remoteReq};
            bitsLeft <= 6'(EXT_HEADER_BITS);
         end else begin
            // ID10..ID0, RTR, IDE
            shiftReg <= {header.ident[10:0], header.remoteReq, header.idExtended, 19'h0};
            bitsLeft <= 6'(STD_HEADER_BITS);
         end
      end else if (bitsLeft != 6'h00) begin
         shiftReg <= {shiftReg[30:0], 1'b0};
         bitsLeft <= bitsLeft - 6'h01;
      end
   end

   // Outputs straight from the register
   assign bitValid = (bitsLeft != 6'h00);
   assign bitOut = shiftReg[31];
   assign done = (bitsLeft == 6'h01);

endmodule

// ### tb/can_bus_node.sv
/*
 Far-side model: a protocol engine that hands a received header to the
 buffer and collects the serial arbitration bits that the buffer sends.
 Assumes one clock shared with the buffer and an active-low async reset.
*/
`timescale 1ns/1ps
module can_bus_node (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Frame to hand over as received
   input wire logic sendReq,
   input can_ident_pkg::frame_hdr_t sendHdr,
   output logic rxStore,
   output can_ident_pkg::frame_hdr_t rxHeader,
   // Serial bits from the buffer
   input wire logic txBitValid,
   input wire logic txBit,
   input wire logic txDone,
   output logic frameDone,
   output logic [31:0] frameWord,
   output logic [5:0] frameLen
);
   import can_ident_pkg::*;
   logic [31:0] shiftReg;
   logic [5:0] bitCount;
   // Header held for one cycle; lines toggle between frames
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rxStore <= 1'b0;
         rxHeader <= '0;
      end else begin
         rxStore <= sendReq;
         rxHeader <= sendReq ? sendHdr : ~rxHeader;
      end
   end
   // First bit sent ends up at bit frameLen-1 of the word, the top only for a 32-bit frame
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         shiftReg <= 32'h0;
         bitCount <= 6'h00;
         frameDone <= 1'b0;
         frameWord <= 32'h0;
         frameLen <= 6'h00;
      end else begin
         frameDone <= 1'b0;
         if (txBitValid) begin
            shiftReg <= {shiftReg[30:0], txBit};
            bitCount <= bitCount + 6'h01;
         end
         if (txBitValid && txDone) begin
            frameWord <= {shiftReg[30:0], txBit};
            frameLen <= bitCount + 6'h01;
            frameDone <= 1'b1;
            bitCount <= 6'h00;
            shiftReg <= 32'h0;
         end
      end
   end
endmodule

// ### tb/tb_top.sv
/*
 Self-checking bench for the identifier bytes: register access, serial
 send in both layouts, receive capture and priority compare.
 Assumes the far-side model in can_bus_node and one 125 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
   import can_ident_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0, regRead = 1'b0, txStart = 1'b0, sendReq = 1'b0, rdLate = 1'b0;
   logic rxStore, txBitValid, txBit, txDone, winsPriority, frameDone;
   logic [7:0] regRdata;
   frame_hdr_t rxHeader, txHeader, h, sendHdr = '0, otherHeader = '0;
   logic [31:0] frameWord;
   logic [5:0] frameLen;
   logic [7:0] readQ[$];
   logic [37:0] serQ[$];
   logic [7:0] b[4];
   logic [28:0] id;
   int errCount = 0, checksDone = 0, cycles = 0;
   always #4 clock = ~clock;
   can_ident_fields dut (.clock(clock), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rxStore(rxStore),
      .rxHeader(rxHeader), .txHeader(txHeader), .txStart(txStart), .txBitValid(txBitValid),
      .txBit(txBit), .txDone(txDone), .otherHeader(otherHeader), .winsPriority(winsPriority));
   can_bus_node node (.clock(clock), .resetn(resetn), .sendReq(sendReq), .sendHdr(sendHdr),
      .rxStore(rxStore), .rxHeader(rxHeader), .txBitValid(txBitValid), .txBit(txBit),
      .txDone(txDone), .frameDone(frameDone), .frameWord(frameWord), .frameLen(frameLen));
   // ------------------------------------------------------------
   // Bus tasks and checking
   // ------------------------------------------------------------
   task automatic tick();
      @(posedge clock);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      txStart <= 1'b0;
      sendReq <= 1'b0;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      regWrite <= 1'b1;
      regRead <= 1'b0;
      regAddr <= a;
      regWdata <= d;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge clock);
      regRead <= 1'b1;
      regWrite <= 1'b0;
      regAddr <= a;
      readQ.push_back(e);
   endtask
   task automatic chk(input string what, input logic [37:0] exp, input logic [37:0] got);
      checksDone++;
      if (got !== exp) begin
         errCount++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reportAndStop();
      if (errCount == 0 && checksDone > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Read data stand in the cycle after the strobe
   always @(posedge clock) rdLate <= regRead;
   // Results taken off the queues as they appear
   always @(negedge clock) begin
      if (rdLate) chk("regRdata", readQ.pop_front(), regRdata);
      if (frameDone) chk("frame", serQ.pop_front(), {frameLen, frameWord});
   end
   // Hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errCount++;
         reportAndStop();
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h0833DF41));
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      // Layout and remote bit in all four combinations
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 4; i++) b[i] = 8'($urandom());
         b[1][3] = k[0];
         b[1][4] = k[0] ? 1'b1 : k[1];
         b[3][0] = k[1];
         for (int i = 0; i < 4; i++) wr(2'(i), b[i]);
         for (int i = 0; i < 4; i++) if (k[0]) rd(2'(i), b[i]);
         tick();
         repeat (2) @(posedge clock);
         id = {b[0], b[1][7:5], b[1][2:0], b[2], b[3][7:1]};
         if (k[0]) serQ.push_back({6'(EXT_HEADER_BITS), id[28:18], b[1][4], 1'b1, id[17:0], b[3][0]});
         else serQ.push_back({6'(STD_HEADER_BITS), 19'h0, b[0], b[1][7:5], b[1][4], 1'b0});
         // Decoded header as the engine sees it
         @(negedge clock);
         if (k[0]) chk("txHeader", 38'({id, b[1][4], 1'b1, b[3][0]}), 38'(txHeader));
         else chk("txHeader", 38'({18'h0, b[0], b[1][7:5], 2'b00, b[1][4]}), 38'(txHeader));
         @(posedge clock);
         txStart <= 1'b1;
         tick();
         repeat (36) @(posedge clock);
      end
      // Smaller identifier wins, ties win
      for (int d = -1; d < 2; d++) begin
         @(posedge clock);
         otherHeader <= {29'(id + d), 1'b1, 1'b1, b[3][0]};
         @(posedge clock);
         @(posedge clock);
         @(negedge clock);
         chk("winsPriority", 38'(id <= 29'(id + d)), 38'(winsPriority));
      end
      // Received headers land in the standard, then the extended layout
      for (int r = 0; r < 2; r++) begin
         h = 32'($urandom());
         h.idExtended = r[0];
         @(posedge clock);
         sendHdr <= h;
         sendReq <= 1'b1;
         tick();
         repeat (3) @(posedge clock);
         @(negedge clock);
         if (r[0]) chk("txHeader", 38'(h), 38'(txHeader));
         else chk("txHeader", 38'({18'h0, h.ident[10:0], 2'b00, h.remoteReq}), 38'(txHeader));
         if (r[0]) begin
            rd(2'h0, h.ident[28:21]);
            rd(2'h1, {h.ident[20:18], h.subRemote, h.idExtended, h.ident[17:15]});
            rd(2'h2, h.ident[14:7]);
            rd(2'h3, {h.ident[6:0], h.remoteReq});
         end else begin
            // Unused low bits of byte 1 are zero-filled on receive
            rd(2'h0, h.ident[10:3]);
            rd(2'h1, {h.ident[2:0], h.remoteReq, 1'b0, 3'h0});
         end
         tick();
      end
      repeat (4) @(posedge clock);
      reportAndStop();
   end
endmodule
